// [hw/hda_map.svh]
// Purpose: constants for the parameter responder
// Assumes: included by bare name from hw/
// Notes:   parameter ids double as word offsets
//
// Functional notes
// RULE_01 - Unsupported verb answers 32 zero bits
// RULE_02 - Unknown parameter id answers all zeros
// RULE_03 - Controller packs address, node, verb, parameter
// RULE_04 - Parameters are read-only, per-widget subsets
// RULE_05 - Root id word: maker code, part code
// RULE_06 - Revision word: zeros, major, minor, rev, step
// RULE_07 - Widget type code in bits 23:20
// RULE_08 - Delay field, stereo bit, reserved zeros
// RULE_09 - Capability single-bit flags at fixed positions
// RULE_10 - Connection flag set means list must be read
// RULE_11 - Sample size support bits 20 down to 16
// RULE_12 - One rate bit each, 8k to 384k
// RULE_13 - Converter with format override answers own
// RULE_14 - Input amp word: mute, step, count, offset
// RULE_15 - Output amp word uses same layout
// RULE_16 - Quarter-dB step size, zero count fixed
// RULE_17 - Amp override widgets answer their own words
// RULE_18 - GPIO word bit 31 zero, no wake
// RULE_19 - D3 keeps settings until reset
// RULE_20 - D3 wake events use normal response path
// RULE_21 - No bit clock: drive data-in high
// RULE_22 - Solicited answer goes out next frame
// RULE_23 - 36-bit frame, valid bit 35, unsol 34
// RULE_24 - Unsolicited tag sits in bits 31:28
// RULE_25 - Own address only; missing nodes answer zero
`ifndef HDA_MAP_SVH
`define HDA_MAP_SVH

// ----------------------------------------------------------
// Verb and parameter ids
// ----------------------------------------------------------
`define VERB_GET_PARAM 12'hf00
`define PID_IDENT      8'h00
`define PID_REVISION   8'h02
`define PID_WCAPS      8'h09
`define PID_PCM        8'h0a
`define PID_IN_AMP     8'h0d
`define PID_GPIO       8'h11
`define PID_OUT_AMP    8'h12

// ----------------------------------------------------------
// Node map and widget types
// ----------------------------------------------------------
`define NODE_ROOT 8'h00
`define NODE_AFG  8'h01
`define NODE_DAC  8'h02
`define NODE_ADC  8'h08
`define NODE_MIX  8'h0b
`define NODE_PIN  8'h14
`define WT_OUT    4'h0
`define WT_IN     4'h1
`define WT_MIX    4'h2
`define WT_SEL    4'h3
`define WT_PIN    4'h4

// ----------------------------------------------------------
// Capability flag positions and fixed words
// ----------------------------------------------------------
`define WC_PWR      10
`define WC_DIGITAL  9
`define WC_CONN     8
`define WC_UNSOL    7
`define WC_PROC     6
`define WC_RSVD5    5
`define WC_FMT_OVR  4
`define WC_AMP_OVR  3
`define WC_OUT_AMP  2
`define WC_IN_AMP   1
`define WC_STEREO   0
`define SPEC_MAJOR  4'h1
`define SPEC_MINOR  4'h0
`define PCM_DEFAULT 32'h000e_0560
`define PCM_DAC     32'h000e_07e0
`define GPIO_WORD   32'h4000_0002

// ----------------------------------------------------------
// Frame and timing counts
// ----------------------------------------------------------
`define CMD_BITS    6'd40
`define RESP_BITS   6'd36
`define MCLK_NS     20
`define BCLK_LOSS_NS 320

`endif

// [hw/hda_pkg.sv]
// Purpose: shared types for the parameter responder
// Assumes: nothing
// Notes:   constants live in hda_map.svh
package hda_pkg;

  // Command word as shifted in from the link
  typedef struct packed {
    logic [7:0]  rsvd;
    logic [3:0]  addr;
    logic [7:0]  node_ident;
    logic [11:0] verb;
    logic [7:0]  pid;
  } cmd_t;

  // Response frame as shifted out, MSB first
  typedef struct packed {
    logic        valid;
    logic        unsol;
    logic [1:0]  rsvd;
    logic [31:0] data;
  } resp_t;

  // Per-widget description used by the lookup
  typedef struct packed {
    logic        ok;
    logic [3:0]  wtype;
    logic [3:0]  delay;
    logic [10:0] flags;
    logic [31:0] fmt;
    logic [31:0] in_amp;
    logic [31:0] out_amp;
  } wdesc_t;

endpackage

// [hw/param_rom.sv]
// Purpose: combinational answer lookup for parameter queries
// Assumes: inputs are stable registered command fields
// Notes:   every unknown combination answers zero
`timescale 1ns/1ps
`include "hda_map.svh"
module param_rom
  import hda_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h5a3c, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0101, // Arbitrary value
  parameter logic [7:0]  VEND_REV    = 8'h01,    // Arbitrary value
  parameter logic [7:0]  STEP_ID     = 8'h00     // Arbitrary value
)(
  // Query fields
  input  wire logic [7:0]  node_i,
  input  wire logic [11:0] verb_i,
  input  wire logic [7:0]  pid_i,
  // Answer
  output logic [31:0]      word_o
);

  // RULE_14 amp word layout
  // RULE_16 quarter-dB steps
  function automatic logic [31:0] amp(input logic m, input logic [6:0] st,
                                      input logic [6:0] n,
                                      input logic [6:0] off);
    amp = {m, 8'h00, st, 1'b0, n, 1'b0, off};
  endfunction

  // RULE_07 widget type field
  // RULE_08 reserved bits forced zero
  function automatic logic [31:0] wcaps(input wdesc_t w);
    logic [10:0] f;
    f = w.flags;
    f[`WC_RSVD5] = 1'b0;
    wcaps = {8'h00, w.wtype, w.delay, 5'h00, f};
  endfunction

  wdesc_t           d;       // Addressed widget
  logic [31:0]      in_def;  // Group default input amp
  logic [31:0]      out_def; // Group default output amp

  // Widget table, then selection by parameter id
  always_comb begin
    in_def  = amp(1'b1, 7'd3, 7'd39, 7'd23);
    out_def = amp(1'b1, 7'd3, 7'd31, 7'd31);
    d = '0;
    case (node_i)
      // RULE_13 converter owns its format word
      `NODE_DAC: begin
        d = '{1'b1, `WT_OUT, 4'h0, 11'h011, `PCM_DAC, 32'h0, 32'h0};
      end
      // RULE_10 input converter reads a list
      `NODE_ADC: begin
        d = '{1'b1, `WT_IN, 4'h1, 11'h10b, 32'h0,
              amp(1'b1, 7'd3, 7'd31, 7'd0), 32'h0};
      end
      `NODE_MIX: begin
        d = '{1'b1, `WT_MIX, 4'h0, 11'h107, 32'h0, 32'h0, 32'h0};
      end
      // RULE_16 fixed gain, mute only
      `NODE_PIN: begin
        d = '{1'b1, `WT_PIN, 4'h0, 11'h18d, 32'h0, 32'h0,
              amp(1'b1, 7'd0, 7'd0, 7'd0)};
      end
      default: d = '0;
    endcase
    word_o = 32'h0;
    // RULE_01 any verb but get-parameter answers zero
    // RULE_04 no verb here writes anything
    if (verb_i == `VERB_GET_PARAM) begin
      case (pid_i)
        // RULE_05 maker and part code
        `PID_IDENT: begin
          if (node_i == `NODE_ROOT) word_o = {VENDOR_CODE, DEVICE_CODE};
        end
        // RULE_06 revision layout
        `PID_REVISION: begin
          if (node_i == `NODE_ROOT)
            word_o = {8'h00, `SPEC_MAJOR, `SPEC_MINOR, VEND_REV, STEP_ID};
        end
        // RULE_09 flags come from the table
        `PID_WCAPS: begin
          if (d.ok) word_o = wcaps(d);
        end
        // RULE_11 size bits, RULE_12 rate bits
        `PID_PCM: begin
          if (node_i == `NODE_AFG)
            word_o = `PCM_DEFAULT;
          else if (d.ok && (d.wtype == `WT_OUT || d.wtype == `WT_IN))
            word_o = d.flags[`WC_FMT_OVR] ? d.fmt : `PCM_DEFAULT;
        end
        // RULE_17 override picks own amp word
        `PID_IN_AMP: begin
          if (d.ok && d.flags[`WC_IN_AMP] && d.wtype inside
              {`WT_IN, `WT_MIX, `WT_SEL})
            word_o = d.flags[`WC_AMP_OVR] ? d.in_amp : in_def;
        end
        // RULE_15 same layout for output amp
        `PID_OUT_AMP: begin
          if (d.ok && d.flags[`WC_OUT_AMP] && d.wtype inside
              {`WT_MIX, `WT_PIN})
            word_o = d.flags[`WC_AMP_OVR] ? d.out_amp : out_def;
        end
        // RULE_18 wake bit stays zero
        `PID_GPIO: begin
          if (node_i == `NODE_AFG) word_o = `GPIO_WORD;
        end
        // RULE_02 unknown ids answer zero
        default: word_o = 32'h0;
      endcase
    end
  end

endmodule

// [hw/hda_codec_parameter_responder.sv]
// Purpose: link-side command decoder and responder with D3 wake
// Assumes: sync_i and sdo_i are launched on bclk_i
// Notes:   pad logic ORs the two data-in drivers
`timescale 1ns/1ps
`include "hda_map.svh"
module hda_codec_parameter_responder
  import hda_pkg::*;
#(
  parameter logic [3:0]  CODEC_ADDR  = 4'h0,
  parameter logic [15:0] VENDOR_CODE = 16'h5a3c, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0101, // Arbitrary value
  parameter logic [7:0]  VEND_REV    = 8'h01,    // Arbitrary value
  parameter logic [7:0]  STEP_ID     = 8'h00     // Arbitrary value
)(
  // Clocks and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       bclk_i,
  // Link pins
  input  wire logic       sync_i,
  input  wire logic       sdo_i,
  output logic            sdi_o,
  output logic            sdi_oe_o,
  // Clockless wake drive on the data-in pin
  output logic            wake_o,
  output logic            wake_oe_o,
  // Sense inputs
  input  wire logic       jack_i,
  input  wire logic [1:0] gpio_i,
  // Function group state
  input  wire logic       d3_i,
  input  wire logic       unsol_en_i,
  input  wire logic [3:0] unsol_tag_i,
  // Status
  output logic            bclk_alive_o
);

  // ----------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------
  // Clock loss is judged from a divided copy of the bit clock;
  // a bit clock slower than the loss time reads as stopped
  // Least time, rounded up to whole cycles
  localparam int LOSS_CYC = (`BCLK_LOSS_NS + `MCLK_NS - 1) / `MCLK_NS;
  localparam int LW       = $clog2(LOSS_CYC + 1);

  // Address 15 is kept back for broadcast and refused
  if (CODEC_ADDR == 4'hf) begin : g_chk
    $error("CODEC_ADDR 15 is reserved for broadcast");
  end

  // ----------------------------------------------------------
  // System clock side: sense, clock watch, wake
  // ----------------------------------------------------------
  logic [2:0]    sn1_r, sn2_r, sn3_r; // Sense synchroniser, history
  logic          bd1_r, bd2_r, bd3_r; // Bit clock divider watch
  logic [LW-1:0] lcnt_r, lcnt_nxt;    // Cycles since divider moved
  logic          alive_r, alive_nxt;  // Bit clock seen running
  logic          wake_r, wake_nxt;    // Data-in held high
  logic          etg_r, etg_nxt;      // Event toggle to link side
  logic [31:0]   ewd_r, ewd_nxt;      // Event word, held for link
  logic          bdiv_r, bdiv_nxt;    // Link-side divider
  logic          ev_fire;             // Sense change this cycle

  // Synchronisers only shift; logic reads only the second and third stages
  always_ff @(posedge mclk_i) begin
    sn1_r <= {jack_i, gpio_i};
    sn2_r <= sn1_r;
    sn3_r <= sn2_r;
    bd1_r <= bdiv_r;
    bd2_r <= bd1_r;
    bd3_r <= bd2_r;
  end

  // Next values for the system side
  always_comb begin
    // RULE_20 jack and GPIO changes raise events in D3 or when enabled
    ev_fire  = (sn2_r != sn3_r) && (d3_i || unsol_en_i);
    lcnt_nxt = lcnt_r;
    if (bd2_r != bd3_r)
      lcnt_nxt = '0;
    else if (lcnt_r != LW'(LOSS_CYC))
      lcnt_nxt = lcnt_r + LW'(1);
    alive_nxt = (lcnt_r != LW'(LOSS_CYC));
    etg_nxt   = etg_r ^ ev_fire;
    ewd_nxt   = ev_fire ? {unsol_tag_i, 25'h0, sn2_r} : ewd_r;
    // RULE_21 no clock in D3: request wake, set wins
    if (ev_fire && d3_i && !alive_r)
      wake_nxt = 1'b1;
    else if (alive_r)
      wake_nxt = 1'b0;
    else
      wake_nxt = wake_r;
  end

  // RULE_19 only reset_i clears held state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lcnt_r  <= '0;
      alive_r <= 1'b0;
      wake_r  <= 1'b0;
      etg_r   <= 1'b0;
      ewd_r   <= 32'h0;
    end else begin
      lcnt_r  <= lcnt_nxt;
      alive_r <= alive_nxt;
      wake_r  <= wake_nxt;
      etg_r   <= etg_nxt;
      ewd_r   <= ewd_nxt;
    end
  end

  assign wake_o       = wake_r;
  assign wake_oe_o    = wake_r;
  assign bclk_alive_o = alive_r;

  // ----------------------------------------------------------
  // Link side: frame decode and response shifter
  // ----------------------------------------------------------
  logic        lr1_r, lr2_r;         // Reset synchroniser
  logic        e1_r, e2_r, e3_r;     // Event toggle synchroniser
  logic        syd_r;                // Previous frame sync
  logic [5:0]  cnt_r, cnt_nxt;       // Command bits taken
  logic [39:0] csr_r, csr_nxt;       // Command shift register
  logic        sp_r, sp_nxt;         // Solicited answer pending
  logic [31:0] sw_r, sw_nxt;         // Solicited answer word
  logic        up_r, up_nxt;         // Unsolicited report pending
  logic [31:0] uw_r, uw_nxt;         // Unsolicited word
  resp_t       tx_r, tx_nxt;         // Outgoing frame
  logic [5:0]  tl_r, tl_nxt;         // Bits left to send
  logic        sdi_r, sdi_nxt;       // Data-in bit
  logic        oe_r, oe_nxt;         // Data-in enable
  logic        fstart;               // Rising frame sync
  logic        cdone;                // Full command received
  logic        own;                  // Addressed to this codec
  cmd_t        cmd;                  // Command fields
  logic [31:0] rom_word;             // Lookup answer

  assign cmd    = cmd_t'(csr_r);
  assign fstart = sync_i && !syd_r;
  assign cdone  = (cnt_r == `CMD_BITS);
  // RULE_03 fields taken at their fixed places
  // RULE_25 other addresses are ignored
  assign own    = (cmd.addr == CODEC_ADDR);

  param_rom #(
    .VENDOR_CODE (VENDOR_CODE),
    .DEVICE_CODE (DEVICE_CODE),
    .VEND_REV    (VEND_REV),
    .STEP_ID     (STEP_ID)
  ) u_rom (
    .node_i (cmd.node_ident),
    .verb_i (cmd.verb),
    .pid_i  (cmd.pid),
    .word_o (rom_word)
  );

  // The event word has no stages of its own: it has stood still for
  // two bit clocks by the time the toggle is seen, so it is safe
  // Reset and event crossings into the link clock
  always_ff @(posedge bclk_i) begin
    lr1_r <= reset_i;
    lr2_r <= lr1_r;
    e1_r  <= etg_r;
    e2_r  <= e1_r;
    e3_r  <= e2_r;
  end

  // Next values for the link side
  always_comb begin
    bdiv_nxt = !bdiv_r;
    cnt_nxt  = cnt_r;
    csr_nxt  = csr_r;
    if (fstart) begin
      cnt_nxt = 6'd1;
      csr_nxt = {39'h0, sdo_i};
    end else if (cnt_r < `CMD_BITS) begin
      cnt_nxt = cnt_r + 6'd1;
      csr_nxt = {csr_r[38:0], sdo_i};
    end else if (cdone) begin
      cnt_nxt = cnt_r + 6'd1;
    end
    sp_nxt = sp_r;
    sw_nxt = sw_r;
    up_nxt = up_r;
    uw_nxt = uw_r;
    tx_nxt = tx_r;
    tl_nxt = tl_r;
    sdi_nxt = 1'b0;
    oe_nxt  = 1'b0;
    // Shift out MSB first while bits remain
    if (tl_r != 6'd0) begin
      sdi_nxt = tx_r[35];
      oe_nxt  = 1'b1;
      tx_nxt  = resp_t'({tx_r[34:0], 1'b0});
      tl_nxt  = tl_r - 6'd1;
    end
    // RULE_22 load the answer at the next frame
    // RULE_23 valid in 35, unsol in 34
    if (fstart && sp_r) begin
      tx_nxt = '{1'b1, 1'b0, 2'b00, sw_r};
      tl_nxt = `RESP_BITS;
      sp_nxt = 1'b0;
    end else if (fstart && up_r) begin
      // RULE_24 tag rides in bits 31:28
      tx_nxt = '{1'b1, 1'b1, 2'b00, uw_r};
      tl_nxt = `RESP_BITS;
      up_nxt = 1'b0;
    end
    // New command: set wins over the take above
    if (cdone && own) begin
      sp_nxt = 1'b1;
      sw_nxt = rom_word;
    end
    // RULE_20 wake report goes the normal way
    if (e2_r != e3_r) begin
      up_nxt = 1'b1;
      uw_nxt = ewd_r;
    end
  end

  // Link registers but syd_r, reset by the synchronised reset: cnt_r loads 63, the rest clear
  always_ff @(posedge bclk_i) begin
    syd_r <= sync_i;
    if (lr2_r) begin
      bdiv_r <= 1'b0;
      cnt_r  <= 6'h3f;
      csr_r  <= 40'h0;
      sp_r   <= 1'b0;
      sw_r   <= 32'h0;
      up_r   <= 1'b0;
      uw_r   <= 32'h0;
      tx_r   <= '0;
      tl_r   <= 6'd0;
      sdi_r  <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      bdiv_r <= bdiv_nxt;
      cnt_r  <= cnt_nxt;
      csr_r  <= csr_nxt;
      sp_r   <= sp_nxt;
      sw_r   <= sw_nxt;
      up_r   <= up_nxt;
      uw_r   <= uw_nxt;
      tx_r   <= tx_nxt;
      tl_r   <= tl_nxt;
      sdi_r  <= sdi_nxt;
      oe_r   <= oe_nxt;
    end
  end

  assign sdi_o    = sdi_r;
  assign sdi_oe_o = oe_r;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_resp_next_frame: assert property (  // RULE_22
    @(posedge bclk_i) disable iff (lr2_r)
    fstart && sp_r |=> tl_r == `RESP_BITS && tx_r.valid && !tx_r.unsol)
    else $error("solicited answer not loaded at frame start");

  a_resp_frame_oe: assert property (  // RULE_23
    @(posedge bclk_i) disable iff (lr2_r)
    fstart && (sp_r || up_r) |-> ##2 (sdi_oe_o && sdi_o) ##1 sdi_oe_o[*8])
    else $error("response frame not driven with valid bit");

  a_unsol_tag: assert property (  // RULE_24
    @(posedge bclk_i) disable iff (lr2_r)
    fstart && !sp_r && up_r |=> tx_r.unsol && tx_r.data == $past(uw_r))
    else $error("unsolicited frame lost its tag or flag");

  a_foreign_addr: assert property (  // RULE_25
    @(posedge bclk_i) disable iff (lr2_r)
    cdone && !own && !sp_r |=> !sp_r)
    else $error("answered a command for another address");

  a_unsup_verb: assert property (  // RULE_01
    @(posedge bclk_i) disable iff (lr2_r)
    cdone && own && cmd.verb != `VERB_GET_PARAM |=> sp_r && sw_r == 32'h0)
    else $error("unsupported verb gave nonzero answer");

  a_unsup_param: assert property (  // RULE_02
    @(posedge bclk_i) disable iff (lr2_r)
    cdone && own && !(cmd.pid inside {`PID_IDENT, `PID_REVISION,
      `PID_WCAPS, `PID_PCM, `PID_IN_AMP, `PID_GPIO, `PID_OUT_AMP})
    |=> sw_r == 32'h0)
    else $error("unknown parameter gave nonzero answer");

  a_ident_word: assert property (  // RULE_05
    @(posedge bclk_i) disable iff (lr2_r)
    cdone && own && cmd.verb == `VERB_GET_PARAM &&
    cmd.node_ident == `NODE_ROOT && cmd.pid == `PID_IDENT
    |=> sw_r == {VENDOR_CODE, DEVICE_CODE})
    else $error("identity word wrong");

  a_gpio_nowake: assert property (  // RULE_18
    @(posedge bclk_i) disable iff (lr2_r)
    cdone && own && cmd.pid == `PID_GPIO |=> !sw_r[31])
    else $error("gpio word claims wake support");

  a_wake_drive: assert property (  // RULE_21
    @(posedge mclk_i) disable iff (reset_i)
    ev_fire && d3_i && !alive_r |=> wake_o && wake_oe_o)
    else $error("wake not driven without bit clock");

  a_wake_release: assert property (  // RULE_21
    @(posedge mclk_i) disable iff (reset_i)
    alive_r && !(ev_fire && d3_i && !alive_r) |=> !wake_o)
    else $error("wake drive held while clock runs");

  a_resp_frame_end: assert property (  // RULE_23
    @(posedge bclk_i) disable iff (lr2_r)
    fstart && (sp_r || up_r) |-> ##38 !sdi_oe_o)
    else $error("response frame longer than 36 bits");

  a_take_pending: assert property (  // RULE_22
    @(posedge bclk_i) disable iff (lr2_r)
    fstart && sp_r && !cdone |=> !sp_r)
    else $error("solicited answer sent twice");

  a_sol_priority: assert property (  // RULE_22
    @(posedge bclk_i) disable iff (lr2_r)
    fstart && sp_r && up_r |=> up_r && !tx_r.unsol)
    else $error("unsolicited report lost behind an answer");

  a_wake_hold: assert property (  // RULE_21
    @(posedge mclk_i) disable iff (reset_i)
    wake_o && !alive_r |=> wake_o)
    else $error("wake drive dropped before clock returned");

  a_clock_loss: assert property (  // RULE_21
    @(posedge mclk_i) disable iff (reset_i)
    lcnt_r == LW'(LOSS_CYC) |=> !bclk_alive_o)
    else $error("stopped bit clock still reported alive");

  // Main scenarios the bench must reach
  c_solicited: cover property (
    @(posedge bclk_i) disable iff (lr2_r) fstart && sp_r);
  c_unsolicited: cover property (
    @(posedge bclk_i) disable iff (lr2_r) fstart && !sp_r && up_r);
  c_wake: cover property (
    @(posedge mclk_i) disable iff (reset_i) $rose(wake_o));
  c_foreign: cover property (
    @(posedge bclk_i) disable iff (lr2_r) cdone && !own);
  c_clock_loss: cover property (
    @(posedge mclk_i) disable iff (reset_i) $fell(bclk_alive_o));

endmodule

// [tb/link_host_model.sv]
// Purpose: host controller model that frames commands, gathers responses
// Assumes: device samples sync and data on the rising bit-clock edge
// Notes:   responses land in resp_q in arrival order
`timescale 1ns/1ps
module link_host_model
  import hda_pkg::*;
(
  // Link clock
  input  wire logic bclk_i,
  // Link pins
  output logic      sync_o,
  output logic      sdo_o,
  input  wire logic sdi_i,
  input  wire logic sdi_oe_i
);
  resp_t       resp_q[$]; // Collected response frames
  logic [35:0] shift_r;   // Response shift register
  int          bits_r;    // Bits gathered so far

  initial begin
    sync_o = 1'b0;
    sdo_o  = 1'b0;
    bits_r = 0;
  end

  // ----------------------------------------------------------
  // Response capture
  // ----------------------------------------------------------
  // Shift in while the device drives; a short burst is dropped
  always @(posedge bclk_i) begin
    if (sdi_oe_i === 1'b1) begin
      shift_r = {shift_r[34:0], sdi_i};
      bits_r  = bits_r + 1;
      if (bits_r == 36) begin
        resp_q.push_back(resp_t'(shift_r));
        bits_r = 0;
      end
    end else begin
      bits_r = 0;
    end
  end

  // ----------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------
  // packed fields, verb passed through unchecked
  task automatic frame(input logic [3:0] addr, input logic [7:0] node,
                       input logic [11:0] verb, input logic [7:0] pid);
    cmd_t c;
    c = '{rsvd: 8'h00, addr: addr, node_ident: node, verb: verb, pid: pid};
    @(negedge bclk_i);
    sync_o = 1'b1;
    for (int i = 39; i >= 0; i--) begin
      sdo_o = c[i];
      @(negedge bclk_i);
      sync_o = 1'b0;
    end
    // Idle gap: data toggles so a stale bit never looks valid
    repeat (4) begin
      sdo_o = ~sdo_o;
      @(negedge bclk_i);
    end
  endtask
endmodule

// [tb/hda_codec_parameter_responder_bench.sv]
// Purpose: self-checking bench for the parameter responder
// Assumes: host model drives the link, bench drives sense and state
// Notes:   identity values below are arbitrary
`timescale 1ns/1ps
`include "hda_map.svh"
module hda_codec_parameter_responder_bench
  import hda_pkg::*;
;
  localparam logic [3:0]  CODEC = 4'h3;    // Non-zero to test decode
  localparam logic [15:0] VEN   = 16'h1a2b; // Arbitrary value
  localparam logic [15:0] DEV   = 16'h0c0d; // Arbitrary value
  localparam logic [7:0]  REV   = 8'h05;    // Arbitrary value
  localparam logic [7:0]  STEP  = 8'h07;    // Arbitrary value

  logic       mclk = 1'b0;  // System clock
  logic       bclk = 1'b0;  // Link bit clock
  logic       bclk_run = 1'b1; // Bit clock gate
  logic       reset = 1'b1; // Synchronous reset
  logic       sync, sdo, sdi, sdi_oe, wake, wake_oe, alive;
  logic       jack = 1'b0;  // Jack sense
  logic [1:0] gpio = 2'b00; // Gpio sense
  logic       d3 = 1'b0;    // Low-power state
  logic       unsol_en = 1'b0; // Unsolicited enable
  logic [3:0] tag = 4'ha;   // Unsolicited tag
  int         error_cnt = 0; // Mismatches
  int         tests_run = 0; // Comparisons
  int         cycles = 0;   // Timeout counter

  always #10 mclk = ~mclk;
  // Gated so the wake path can see a dead link
  always #16 if (bclk_run) bclk = ~bclk;

  hda_codec_parameter_responder #(.CODEC_ADDR(CODEC), .VENDOR_CODE(VEN),
    .DEVICE_CODE(DEV), .VEND_REV(REV), .STEP_ID(STEP)) DUT (
    .mclk_i(mclk), .reset_i(reset), .bclk_i(bclk), .sync_i(sync),
    .sdo_i(sdo), .sdi_o(sdi), .sdi_oe_o(sdi_oe), .wake_o(wake),
    .wake_oe_o(wake_oe), .jack_i(jack), .gpio_i(gpio), .d3_i(d3),
    .unsol_en_i(unsol_en), .unsol_tag_i(tag), .bclk_alive_o(alive));

  link_host_model host (.bclk_i(bclk), .sync_o(sync), .sdo_o(sdo),
    .sdi_i(sdi), .sdi_oe_i(sdi_oe));

  // ----------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------
  task automatic chk_word(input string what, input logic [35:0] exp,
                          input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Summary: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Ceiling well above the ~4000 cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------
  // Link transactions
  // ----------------------------------------------------------
  // Exactly one frame expected, then the queue is emptied
  task automatic collect(input logic [35:0] exp);
    resp_t r;
    chk_word("resp count", 36'd1, 36'(host.resp_q.size()));
    if (host.resp_q.size() > 0) begin
      r = host.resp_q.pop_front();
      chk_word("resp frame", exp, r);
    end
    host.resp_q.delete();
  endtask

  // A frame addressed elsewhere carries the answer back
  task automatic query(input logic [7:0] node, input logic [7:0] pid,
                       input logic [31:0] exp,
                       input logic [11:0] verb = `VERB_GET_PARAM);
    int early;
    host.frame(CODEC, node, verb, pid);
    early = host.resp_q.size();
    host.frame(4'hf, 8'h00, 12'h000, 8'h00);
    chk_word("same frame", 36'h0, 36'(early));
    collect({4'h8, exp});
  endtask

  task automatic idle_frames();
    host.frame(4'hf, 8'h00, 12'h000, 8'h00);
    host.frame(4'hf, 8'h00, 12'h000, 8'h00);
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    repeat (10) @(negedge mclk);
    query(`NODE_ROOT, `PID_IDENT, {VEN, DEV});
    query(`NODE_ROOT, `PID_REVISION,
          {8'h00, `SPEC_MAJOR, `SPEC_MINOR, REV, STEP});
    query(`NODE_DAC, `PID_WCAPS, 32'h0000_0011);
    query(`NODE_ADC, `PID_WCAPS, 32'h0011_010b);
    query(`NODE_MIX, `PID_WCAPS, 32'h0020_0107);
    query(`NODE_PIN, `PID_WCAPS, 32'h0040_018d);
    $display("Test capabilities done");
    query(`NODE_AFG, `PID_PCM, `PCM_DEFAULT);
    query(`NODE_DAC, `PID_PCM, `PCM_DAC);
    query(`NODE_ADC, `PID_PCM, `PCM_DEFAULT);
    query(`NODE_MIX, `PID_IN_AMP, 32'h8003_2717);
    query(`NODE_MIX, `PID_OUT_AMP, 32'h8003_1f1f);
    query(`NODE_PIN, `PID_OUT_AMP, 32'h8000_0000);
    query(`NODE_AFG, `PID_GPIO, `GPIO_WORD);
    $display("Test formats done");
    query(`NODE_ROOT, 8'h7f, 32'h0);
    query(`NODE_ROOT, `PID_IDENT, 32'h0, 12'hf03);
    query(8'h30, `PID_IDENT, 32'h0);
    query(`NODE_ROOT, `PID_WCAPS, 32'h0);
    query(`NODE_AFG, `PID_IDENT, 32'h0);
    host.frame(4'h5, `NODE_ROOT, `VERB_GET_PARAM, `PID_IDENT);
    idle_frames();
    chk_word("foreign", 36'h0, 36'(host.resp_q.size()));
    $display("Test refusals done");
    @(negedge mclk);
    unsol_en = 1'b1;
    jack = 1'b1;
    repeat (20) @(negedge mclk);
    idle_frames();
    collect({4'hc, tag, 25'h0, 3'b100});
    @(negedge mclk);
    unsol_en = 1'b0;
    d3 = 1'b1;
    gpio = 2'b01;
    repeat (20) @(negedge mclk);
    idle_frames();
    collect({4'hc, tag, 25'h0, 3'b101});
    $display("Test events done");
    @(negedge mclk);
    bclk_run = 1'b0;
    repeat (40) @(negedge mclk);
    chk_pin("alive", 1'b0, alive);
    chk_pin("wake idle", 1'b0, wake);
    jack = 1'b0;
    repeat (6) @(negedge mclk);
    chk_pin("wake", 1'b1, wake);
    chk_pin("wake oe", 1'b1, wake_oe);
    bclk_run = 1'b1;
    for (int i = 0; i < 50 && alive !== 1'b1; i++) begin
      @(negedge mclk);
    end
    repeat (2) @(negedge mclk);
    chk_pin("wake end", 1'b0, wake);
    idle_frames();
    collect({4'hc, tag, 25'h0, 3'b001});
    d3 = 1'b0;
    query(`NODE_ROOT, `PID_IDENT, {VEN, DEV});
    $display("Test wake done");
    conclude();
  end
endmodule
